// File: logic/sscd_divider.sv
// Purpose: counts ticks and emits a divided clock level and its edge
// Assumes: ratio is at least 1 and steady while run is high
// Notes: edge_now is combinational so that cascaded dividers share edges
`timescale 1ns/100ps
module sscd_divider #(
    parameter int W = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] ratio,
    // divided clock
    output logic edge_now,
    output logic edge_q,
    output logic level_q
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic [W-1:0] half;
    logic level_d;

    always_comb
    begin
        half = W'((ratio + W'(1)) >> 1);
        edge_now = run && tick && (cnt_q == '0);
        cnt_d = cnt_q;
        if (!run)
            cnt_d = '0;
        else if (tick)
            cnt_d = (cnt_q == ratio - W'(1)) ? '0 : cnt_q + W'(1);
        // odd ratios give a longer high phase; ratio 1 stays high
        level_d = run && (cnt_d < half);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= '0;
            edge_q <= 1'b0;
            level_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            edge_q <= edge_now;
            level_q <= level_d;
        end
    end
endmodule : sscd_divider

// File: logic/sscd_pkg.sv
// Purpose: shared constants, types and decoders of the divider block
// Assumes: one aligned 32-bit word per register on APB
// Notes: codes index the legal divide sets; other codes are refused
package sscd_pkg;

    // register map
    localparam logic [31:0] SSCD_BASE = 32'h40038000;
    localparam logic [31:0] SSCD_OFF_CFG1 = 32'h00000098;
    localparam logic [31:0] SSCD_OFF_CFG2 = 32'h0000009C;

    // divider_config_one fields, three-bit codes
    localparam int SSCD_FW = 3;
    localparam int SSCD_NF = 4;
    localparam int SSCD_F_MULT = 0;
    localparam int SSCD_F_DFAB = 4;
    localparam int SSCD_F_FAB0 = 8;
    localparam int SSCD_F_FAB1 = 12;
    localparam logic [31:0] SSCD_CFG1_RST = 32'h00002211;
    localparam logic [31:0] SSCD_CFG1_MASK = 32'h00007777;

    // divider_config_two fields
    localparam int SSCD_F_PROT = 0;
    localparam int SSCD_F_LOCK = 8;
    localparam int SSCD_F_SEL = 9;
    localparam int SSCD_F_REL = 10;
    localparam int SSCD_F_L1 = 11;
    localparam logic [3:0] SSCD_PROT_RST = 4'h0;

    localparam int SSCD_RW = 6;

    typedef enum logic [3:0] {
        SSCD_ST_STANDBY = 4'b0001,
        SSCD_ST_SWITCH = 4'b0010,
        SSCD_ST_RELEASE = 4'b0100,
        SSCD_ST_RUN = 4'b1000
    } sscd_state_t;

    typedef enum logic [1:0] {
        SSCD_SEL_NONE = 2'h0,
        SSCD_SEL_CFG1 = 2'h1,
        SSCD_SEL_CFG2 = 2'h2
    } sscd_sel_t;

    typedef struct packed {
        logic core;
        logic ddr_fab;
        logic fab0;
        logic fab1;
    } sscd_clk_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } sscd_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sscd_apb_rsp_t;

    function automatic logic [SSCD_RW-1:0] sscd_mult_ratio(
        input logic [2:0] c
    );
        case (c)
            3'h0: sscd_mult_ratio = 6'h01;
            3'h1: sscd_mult_ratio = 6'h02;
            3'h2: sscd_mult_ratio = 6'h03;
            3'h3: sscd_mult_ratio = 6'h04;
            3'h4: sscd_mult_ratio = 6'h06;
            default: sscd_mult_ratio = 6'h08;
        endcase
    endfunction : sscd_mult_ratio

    function automatic logic [SSCD_RW-1:0] sscd_dfab_ratio(
        input logic [2:0] c
    );
        case (c)
            3'h6: sscd_dfab_ratio = 6'h0C;
            3'h7: sscd_dfab_ratio = 6'h10;
            default: sscd_dfab_ratio = sscd_mult_ratio(c);
        endcase
    endfunction : sscd_dfab_ratio

    function automatic logic [SSCD_RW-1:0] sscd_fab_ratio(
        input logic [2:0] c
    );
        sscd_fab_ratio = SSCD_RW'(6'h01 << c);
    endfunction : sscd_fab_ratio

    // field index 1 takes all eight codes, the others only six
    function automatic logic sscd_code_ok(input int idx, input logic [2:0] c);
        sscd_code_ok = (idx == 1) || (c <= 3'h5);
    endfunction : sscd_code_ok

endpackage : sscd_pkg

// File: logic/sscd_sync2.sv
// Purpose: two-flop synchroniser for a level from outside the clock domain
// Assumes: input is a slow level
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module sscd_sync2 (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // level
    input wire logic d,
    output logic q
);
    logic meta_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : sscd_sync2

// File: logic/sscd_top.sv
// Purpose: subsystem clock dividers, start-up switch and their registers
// Assumes: clk is the undivided source; nrst is the config-controller reset
// Notes: APB answers one cycle into the access phase
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps

module sscd_top
    import sscd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire sscd_pkg::sscd_apb_req_t apb_req,
    output sscd_pkg::sscd_apb_rsp_t apb_rsp,
    // pll status pin
    input wire logic subsystem_pll_lock,
    // divided clocks, levels and one-cycle edge strobes
    output sscd_pkg::sscd_clk_t clk_level_q,
    output sscd_pkg::sscd_clk_t clk_edge_q,
    // start-up control
    output logic clock_select_q,
    output logic ddr_reset_n_q,
    output logic fabric_reset_n_q,
    output logic fabric_link0_lock_q,
    output logic fabric_link1_lock_q
);
    import sscd_pkg::*;

    logic lock_s;
    sscd_state_t state_q;
    sscd_state_t state_d;
    logic [31:0] cfg1_q;
    logic [31:0] cfg1_d;
    logic [3:0] prot_q;
    logic [3:0] prot_d;
    sscd_apb_rsp_t rsp_d;
    logic sel_d;
    logic rel_d;
    logic l0_d;
    logic l1_d;
    sscd_sel_t dec;
    logic acc;
    logic commit;
    logic cfg1_wr;
    logic run;
    logic [31:0] cfg2_rd;
    logic core_now;
    logic [SSCD_RW-1:0] r_mult;
    logic [SSCD_RW-1:0] r_dfab;
    logic [SSCD_RW-1:0] r_fab0;
    logic [SSCD_RW-1:0] r_fab1;

    function automatic sscd_sel_t sscd_decode(input logic [31:0] a);
        if (a == SSCD_BASE + SSCD_OFF_CFG1)
            sscd_decode = SSCD_SEL_CFG1;
        else if (a == SSCD_BASE + SSCD_OFF_CFG2)
            sscd_decode = SSCD_SEL_CFG2;
        else
            sscd_decode = SSCD_SEL_NONE;
    endfunction : sscd_decode

    sscd_sync2 u_lock_sync (
        .clk(clk),
        .nrst(nrst),
        .d(subsystem_pll_lock),
        .q(lock_s)
    );

    // ratios from the stored codes; illegal codes never reach the registers
    always_comb
    begin
        r_mult = sscd_mult_ratio(cfg1_q[SSCD_F_MULT +: SSCD_FW]);
        r_dfab = sscd_dfab_ratio(cfg1_q[SSCD_F_DFAB +: SSCD_FW]);
        r_fab0 = sscd_fab_ratio(cfg1_q[SSCD_F_FAB0 +: SSCD_FW]);
        r_fab1 = sscd_fab_ratio(cfg1_q[SSCD_F_FAB1 +: SSCD_FW]);
    end

    // dividers restart together so every edge lands on a common clk edge
    assign run = (state_q == SSCD_ST_RELEASE || state_q == SSCD_ST_RUN)
        && !cfg1_wr;

    sscd_divider #(.W(SSCD_RW)) u_core (
        .clk(clk),
        .nrst(nrst),
        .run(run),
        .tick(1'b1),
        .ratio(r_mult),
        .edge_now(core_now),
        .edge_q(clk_edge_q.core),
        .level_q(clk_level_q.core)
    );

    sscd_divider #(.W(SSCD_RW)) u_ddr_fab (
        .clk(clk),
        .nrst(nrst),
        .run(run),
        .tick(1'b1),
        .ratio(r_dfab),
        .edge_now(),
        .edge_q(clk_edge_q.ddr_fab),
        .level_q(clk_level_q.ddr_fab)
    );

    // fabric links count core edges, so their edges are core edges
    sscd_divider #(.W(SSCD_RW)) u_fab0 (
        .clk(clk),
        .nrst(nrst),
        .run(run),
        .tick(core_now),
        .ratio(r_fab0),
        .edge_now(),
        .edge_q(clk_edge_q.fab0),
        .level_q(clk_level_q.fab0)
    );

    sscd_divider #(.W(SSCD_RW)) u_fab1 (
        .clk(clk),
        .nrst(nrst),
        .run(run),
        .tick(core_now),
        .ratio(r_fab1),
        .edge_now(),
        .edge_q(clk_edge_q.fab1),
        .level_q(clk_level_q.fab1)
    );

    // start-up sequence
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SSCD_ST_STANDBY:
                if (lock_s)
                    state_d = SSCD_ST_SWITCH;
            SSCD_ST_SWITCH:
                state_d = SSCD_ST_RELEASE;
            SSCD_ST_RELEASE:
                state_d = SSCD_ST_RUN;
            SSCD_ST_RUN:
                if (!lock_s)
                    state_d = SSCD_ST_STANDBY;
            default:
                state_d = SSCD_ST_STANDBY;
        endcase
        if (!lock_s)
            state_d = SSCD_ST_STANDBY;
        sel_d = (state_d != SSCD_ST_STANDBY);
        rel_d = (state_d == SSCD_ST_RUN) && clock_select_q;
        // lock drops while a rewrite realigns the dividers
        l1_d = (state_d == SSCD_ST_RUN) && run;
        l0_d = l1_d;
    end

    // apb decode; access taken at the edge where pready is seen high
    always_comb
    begin
        dec = sscd_decode(apb_req.paddr);
        acc = apb_req.psel && apb_req.penable && !apb_rsp.pready;
        commit = apb_req.psel && apb_req.penable && apb_rsp.pready;
        cfg1_wr = commit && apb_req.pwrite && (dec == SSCD_SEL_CFG1);
        cfg2_rd = '0;
        cfg2_rd[SSCD_F_PROT +: SSCD_NF] = prot_q;
        cfg2_rd[SSCD_F_LOCK] = lock_s;
        cfg2_rd[SSCD_F_SEL] = clock_select_q;
        cfg2_rd[SSCD_F_REL] = ddr_reset_n_q;
        cfg2_rd[SSCD_F_L1] = fabric_link1_lock_q;
        rsp_d.pready = acc;
        rsp_d.pslverr = acc && (dec == SSCD_SEL_NONE);
        rsp_d.prdata = '0;
        if (acc && !apb_req.pwrite)
        begin
            if (dec == SSCD_SEL_CFG1)
                rsp_d.prdata = cfg1_q;
            else if (dec == SSCD_SEL_CFG2)
                rsp_d.prdata = cfg2_rd;
        end
    end

    // register writes: protected fields and illegal codes keep their value
    always_comb
    begin
        cfg1_d = cfg1_q;
        prot_d = prot_q;
        if (cfg1_wr)
        begin
            for (int i = 0; i < SSCD_NF; i++)
            begin
                if (!prot_q[i]
                    && sscd_code_ok(i, apb_req.pwdata[4*i +: SSCD_FW]))
                    cfg1_d[4*i +: SSCD_FW] =
                        apb_req.pwdata[4*i +: SSCD_FW];
            end
        end
        // protection bits only set; nrst alone clears them
        if (commit && apb_req.pwrite && dec == SSCD_SEL_CFG2)
            prot_d = prot_q | apb_req.pwdata[SSCD_F_PROT +: SSCD_NF];
        cfg1_d = cfg1_d & SSCD_CFG1_MASK;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= SSCD_ST_STANDBY;
            cfg1_q <= SSCD_CFG1_RST;
            prot_q <= SSCD_PROT_RST;
            apb_rsp <= '0;
            clock_select_q <= 1'b0;
            ddr_reset_n_q <= 1'b0;
            fabric_reset_n_q <= 1'b0;
            fabric_link0_lock_q <= 1'b0;
            fabric_link1_lock_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cfg1_q <= cfg1_d;
            prot_q <= prot_d;
            apb_rsp <= rsp_d;
            clock_select_q <= sel_d;
            ddr_reset_n_q <= rel_d;
            fabric_reset_n_q <= rel_d;
            fabric_link0_lock_q <= l0_d;
            fabric_link1_lock_q <= l1_d;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_mult_set;
        r_mult inside {6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08};
    endproperty
    a_mult_set: assert property (p_mult_set)
        else $error("ddr multiple outside legal set");

    property p_dfab_set;
        r_dfab inside {6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08,
            6'h0C, 6'h10};
    endproperty
    a_dfab_set: assert property (p_dfab_set)
        else $error("ddr fabric ratio outside legal set");

    property p_fab_set;
        r_fab0 inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20}
            && r_fab1 inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    endproperty
    a_fab_set: assert property (p_fab_set)
        else $error("fabric ratio outside legal set");

    property p_edges_align;
        (clk_edge_q.fab0 || clk_edge_q.fab1) |-> clk_edge_q.core;
    endproperty
    a_edges_align: assert property (p_edges_align)
        else $error("fabric edge without core edge");

    // lock is registered, so it trails the synced pll status by one edge
    property p_lock_valid;
        fabric_link1_lock_q |-> state_q == SSCD_ST_RUN && clock_select_q
            && $past(lock_s);
    endproperty
    a_lock_valid: assert property (p_lock_valid)
        else $error("link lock high while clock not valid");

    property p_release_order;
        $rose(ddr_reset_n_q) |-> clock_select_q && $past(clock_select_q);
    endproperty
    a_release_order: assert property (p_release_order)
        else $error("resets released before mux switch");

    property p_standby;
        !lock_s |=> !clock_select_q && !ddr_reset_n_q;
    endproperty
    a_standby: assert property (p_standby)
        else $error("left standby path without pll lock");

    property p_protect;
        cfg1_wr && prot_q[0] |=> $stable(cfg1_q[SSCD_F_MULT +: SSCD_FW]);
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected field changed on write");

    property p_read_cfg1;
        acc && !apb_req.pwrite && dec == SSCD_SEL_CFG1
            |=> apb_rsp.pready && apb_rsp.prdata == $past(cfg1_q);
    endproperty
    a_read_cfg1: assert property (p_read_cfg1)
        else $error("config one read mismatch");

    property p_read_lock;
        acc && !apb_req.pwrite && dec == SSCD_SEL_CFG2
            |=> apb_rsp.prdata[SSCD_F_LOCK] == $past(lock_s);
    endproperty
    a_read_lock: assert property (p_read_lock)
        else $error("pll lock status read mismatch");

endmodule : sscd_top

// File: tb/sscd_fabric_model.sv
// Purpose: fabric master that works on the link one clock
// Assumes: the link one edge strobe marks its rising edges
// Notes: counts work beats only while the link lock is high
`timescale 1ns/100ps
module sscd_fabric_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // link one from the block
    input wire logic link_edge,
    input wire logic link_lock,
    // work done
    output logic [15:0] beats_q
);
    logic [15:0] beats_d;

    // beats only on link edges, so the master runs at the link rate
    always_comb
    begin
        beats_d = beats_q;
        if (link_edge && link_lock)
        begin
            beats_d = beats_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            beats_q <= 16'h0000;
        end
        else
        begin
            beats_q <= beats_d;
        end
    end
endmodule : sscd_fabric_model

// File: tb/subsystem_clock_divider_config_bench.sv
// Purpose: self-checking bench of the divider block
// Assumes: APB answers after one wait state, lock pin synced by two flops
// Notes: an integer model keeps the expected register contents
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h expected %h", $time, (a), (e)); end end
module subsystem_clock_divider_config_bench;
    import sscd_pkg::*;
    localparam logic [31:0] A1 = SSCD_BASE + SSCD_OFF_CFG1;
    localparam logic [31:0] A2 = SSCD_BASE + SSCD_OFF_CFG2;
    logic clk, nrst, pll, err;
    logic csel, ddr_rn, fab_rn, lk0, lk1;
    sscd_apb_req_t req;
    sscd_apb_rsp_t rsp;
    sscd_clk_t lvl, edg;
    logic [15:0] beats;
    logic [31:0] rd, b4;
    int fails, total_checks, cyc, seed, cfg1_m, prot_m, i, m, f0, f1;
    int mr[8];

    // clk stands for the base clock that the fabric side feeds in
    sscd_top dut (.clk(clk),
        .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
        .subsystem_pll_lock(pll), .clk_level_q(lvl), .clk_edge_q(edg),
        .clock_select_q(csel), .ddr_reset_n_q(ddr_rn),
        .fabric_reset_n_q(fab_rn), .fabric_link0_lock_q(lk0),
        .fabric_link1_lock_q(lk1));
    sscd_fabric_model fab (.clk(clk), .nrst(nrst), .link_edge(edg.fab1),
        .link_lock(lk1), .beats_q(beats));

    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    // longest test needs some 2000 cycles; leave a wide margin
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fails++;
            complete_run();
        end
    end

    // outputs are sampled on the falling edge, clear of edge updates
    always @(negedge clk)
    begin
        if (edg.fab0 || edg.fab1)
        begin
            `CHK(edg.core, 1'h1)
        end
    end

    task automatic apb(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        @(posedge clk);
        req <= '{1'h1, 1'h0, w, a, d};
        @(posedge clk);
        req.penable <= 1'h1;
        do @(posedge clk); while (rsp.pready !== 1'h1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        if (w && a == A2)
            prot_m = prot_m | int'(d[3:0]);
        // a protected field or an illegal code leaves the field as it was
        if (w && a == A1)
            for (int f = 0; f < 4; f++)
                if (!prot_m[f] && (f == 1 || d[4*f+:3] <= 3'h5))
                    cfg1_m[4*f+:3] = d[4*f+:3];
    endtask : apb

    task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h00000000);
        `CHK(rd, e)
    endtask : rdchk

    task automatic waitn(input int n);
        repeat (n) @(negedge clk);
    endtask : waitn

    // period in clk cycles and cycles with the level high over that period
    task automatic meas(input int b, input int e, input int h);
        int n;
        int hi;
        n = 0;
        hi = 0;
        while (edg[b] !== 1'h1) @(negedge clk);
        do
        begin
            @(negedge clk);
            n++;
            if (lvl[b] === 1'h1)
                hi++;
        end
        while (edg[b] !== 1'h1);
        `CHK(n, e)
        `CHK(hi, h)
    endtask : meas

    task automatic complete_run();
        if (fails == 0 && total_checks > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    initial
    begin
        mr = '{1, 2, 3, 4, 6, 8, 12, 16};
        seed = 28;
        nrst = 1'h0;
        pll = 1'h0;
        req = '0;
        cfg1_m = SSCD_CFG1_RST;
        prot_m = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'h1;
        `CHK({csel, ddr_rn, lk1, edg}, 7'h00)
        rdchk(A1, SSCD_CFG1_RST);
        rdchk(A2, 32'h00000000);
        apb(1'h1, SSCD_BASE + 32'h000000A0, 32'hFFFFFFFF);
        `CHK(err, 1'h1)
        rdchk(SSCD_BASE + 32'h000000A0, 32'h00000000);
        rdchk(A1, cfg1_m);
        `CHK(beats, 16'h0000)
        @(posedge clk);
        pll <= 1'h1;
        while (csel !== 1'h1) @(negedge clk);
        `CHK({ddr_rn, fab_rn, lk1}, 3'h0)
        waitn(2);
        `CHK({ddr_rn, fab_rn, lk0, lk1}, 4'hF)
        rdchk(A2, 32'h00000F00);
        for (i = 0; i < 8; i++)
        begin
            m = i % 6;
            f0 = {$random(seed)} % 6;
            f1 = 5 - m;
            apb(1'h1, A1, 32'(m | i << 4 | f0 << 8 | f1 << 12));
            rdchk(A1, cfg1_m);
            waitn(4);
            while (lk1 !== 1'h1) @(negedge clk);
            fork
                meas(3, mr[m], (mr[m] + 1) / 2);
                meas(2, mr[i], (mr[i] + 1) / 2);
                meas(1, mr[m] << f0,
                    mr[m] * (((1 << f0) + 1) / 2));
                meas(0, mr[m] << f1,
                    mr[m] * (((1 << f1) + 1) / 2));
            join
        end
        `CHK(beats != 16'h0000, 1'h1)
        apb(1'h1, A1, 32'hFFFFFFFF);
        rdchk(A1, cfg1_m);
        apb(1'h1, A2, 32'h00000005);
        apb(1'h1, A2, 32'h00000000);
        rdchk(A2, 32'(prot_m) | 32'h00000F00);
        apb(1'h1, A1, 32'h00000000);
        rdchk(A1, cfg1_m);
        @(posedge clk);
        pll <= 1'h0;
        waitn(5);
        `CHK({csel, ddr_rn, fab_rn, lk0, lk1}, 5'h00)
        b4 = 32'(beats);
        waitn(40);
        `CHK(beats, b4[15:0])
        @(posedge clk);
        nrst <= 1'h0;
        repeat (8) @(posedge clk);
        nrst <= 1'h1;
        cfg1_m = SSCD_CFG1_RST;
        prot_m = 0;
        rdchk(A1, SSCD_CFG1_RST);
        rdchk(A2, 32'h00000000);
        complete_run();
    end
endmodule : subsystem_clock_divider_config_bench
